// File: hw/lcdf_pkg.sv
// Constants, codes and state encodings of the display driver bus front end.
// Assumes nothing; compiled before every other design file.
`default_nettype none
package lcdf_pkg;
	// ==========================================
	// Bus address and byte framing
	localparam logic [5:0] ADDR_PREFIX = 6'h1c;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// ==========================================
	// Command identifiers
	localparam logic [1:0] OP_MODE = 2'h2;
	localparam logic [3:0] OP_DEVSEL = 4'hc;
	localparam logic [4:0] OP_BANK = 5'h1e;
	localparam logic [3:0] OP_BLINK = 4'he;
	// ==========================================
	// Drive modes and pointer steps
	localparam logic [1:0] MODE_STATIC = 2'h1;
	localparam logic [1:0] MODE_2BP = 2'h2;
	localparam logic [1:0] MODE_3BP = 2'h3;
	localparam logic [1:0] MODE_4BP = 2'h0;
	localparam logic [5:0] STEP_STATIC = 6'h08;
	localparam logic [5:0] STEP_2BP = 6'h04;
	localparam logic [5:0] STEP_3BP = 6'h03;
	localparam logic [5:0] STEP_4BP = 6'h02;
	localparam logic [5:0] PTR_LAST = 6'h27;
	localparam logic [5:0] RAM_WORDS = 6'h28;
	// ==========================================
	// Reset values
	localparam logic [1:0] RST_MODE = MODE_4BP;
	localparam logic [5:0] RST_PTR = 6'h00;
	localparam logic [2:0] RST_SUB = 3'h0;
	// ==========================================
	// Blink dividers, in display clock ticks
	localparam int BLINK_DIV1 = 768;
	localparam int BLINK_DIV2 = 1536;
	localparam int BLINK_DIV3 = 3072;
	localparam logic [10:0] BLINK_HALF1 = 11'(BLINK_DIV1 / 2);
	localparam logic [10:0] BLINK_HALF2 = 11'(BLINK_DIV2 / 2);
	localparam logic [10:0] BLINK_HALF3 = 11'(BLINK_DIV3 / 2);
	// ==========================================
	// Write stream
	localparam int FIFO_DEPTH = 16;
	localparam int WR_W = 15;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ADDR = 6'h02,
		ST_CMD = 6'h04,
		ST_DATA = 6'h08,
		ST_ACK = 6'h10,
		ST_IGN = 6'h20
	} lcdf_st_t;
endpackage
`default_nettype wire

// File: hw/lcdf_if.sv
// Valid/ready word stream between the front end and its FIFO.
// Assumes both ends share one clock.
`timescale 1ns/10ps
`default_nettype none
interface lcdf_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// File: hw/lcdf_fifo.sv
// Synchronous FIFO for display write words.
// Assumes DEPTH is a power of two so the pointers wrap by themselves.
`timescale 1ns/10ps
`default_nettype none
module lcdf_fifo import lcdf_pkg::*; #(
	parameter int W = WR_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_rst,
	lcdf_if.snk wr,
	lcdf_if.src rd
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} lcdf_fifo_st_t;
	lcdf_fifo_st_t r_reg;
	lcdf_fifo_st_t r_next;
	logic push;
	logic pop;
	// ==========================================
	// Handshake; full refuses, empty withholds
	assign push = wr.valid && wr.ready;
	assign pop = rd.valid && rd.ready;
	assign wr.ready = (r_reg.cnt != (AW+1)'(DEPTH));
	assign rd.valid = (r_reg.cnt != '0);
	assign rd.data = r_reg.mem[r_reg.rp];
	// Next state
	always_comb begin
		r_next = r_reg;
		if (push) begin
			r_next.mem[r_reg.wp] = wr.data;
			r_next.wp = r_reg.wp + 1'b1;
		end
		if (pop) begin
			r_next.rp = r_reg.rp + 1'b1;
		end
		r_next.cnt = r_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end
	// State register
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end
endmodule // lcdf_fifo
`default_nettype wire

// File: hw/lcdf_blink.sv
// Blink phase generator driven by the display clock enable.
// Assumes i_tick is a one-cycle pulse at the display clock rate.
`timescale 1ns/10ps
`default_nettype none
module lcdf_blink import lcdf_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_tick,
	input wire logic [1:0] i_rate,
	output logic o_phase
);
	typedef struct packed {
		logic [10:0] cnt;
		logic phase;
	} lcdf_blink_st_t;
	lcdf_blink_st_t r_reg;
	lcdf_blink_st_t r_next;
	logic [10:0] half;
	// ==========================================
	// Half period per rate; phase toggles twice per blink
	always_comb begin
		r_next = r_reg;
		unique case (i_rate)
			2'h1: half = BLINK_HALF1;
			2'h2: half = BLINK_HALF2;
			default: half = BLINK_HALF3;
		endcase
		if (i_rate == 2'h0) begin
			r_next = '0;
		end else if (i_tick) begin
			if (r_reg.cnt >= half - 11'h001) begin
				r_next.cnt = '0;
				r_next.phase = !r_reg.phase;
			end else begin
				r_next.cnt = r_reg.cnt + 11'h001;
			end
		end
	end
	// State register
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end
	assign o_phase = r_reg.phase;
endmodule // lcdf_blink
`default_nettype wire

// File: hw/lcdf_front.sv
// Two-wire write-only slave front end of a segment display driver.
// Assumes SCL/SDA are already synchronous and filtered; display RAM sits
// behind the o_wr_* stream, and i_disp_tick is the display clock enable.
// Summary of operation
// - Receive only; drive SDA solely for acknowledge.
// - Answer two addresses sharing upper bits 011100.
// - Address bit 1 must equal strap level.
// - Read accesses are never answered.
// - Matching devices acknowledge; others ignore transfer.
// - Command bit 7 set means another command.
// - Every selected device acknowledges each command.
// - Data byte stored at pointer and subaddress.
// - Data acknowledged only when subaddress matches straps.
// - Mode-set selects drive mode and bias.
// - Mode-set bit 3 enables the display.
// - Load-data-pointer loads six-bit RAM address.
// - Device-select loads the subaddress counter.
// - Bank-select sets input and output banks.
// - Bank-select ignored in three/four backplane modes.
// - Blink-select sets blink mode and rate.
// - Alternate blinking becomes normal in multiplex 3/4.
// - Blink rates divide display clock 768/1536/3072.
// - Pointer step per byte 8/4/3/2 by mode.
// - Mismatch skips write; overflow bumps subaddress.
`timescale 1ns/10ps
`default_nettype none
module lcdf_front import lcdf_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_o,
	output logic o_sda_oe,
	input wire logic i_addr_select_strap,
	input wire logic [2:0] i_hw_subaddress_straps,
	input wire logic i_disp_tick,
	output logic [1:0] o_drive_mode,
	output logic o_bias_half,
	output logic o_disp_visible,
	output logic o_bank_in,
	output logic o_bank_out,
	output logic [1:0] o_blink_rate_field,
	output logic o_blink_alt,
	output logic [5:0] o_data_ptr,
	output logic [2:0] o_sub_cnt,
	output logic o_wr_valid,
	input wire logic i_wr_ready,
	output logic [5:0] o_wr_addr,
	output logic o_wr_bank,
	output logic [7:0] o_wr_data
);
	typedef struct packed {
		lcdf_st_t st;
		lcdf_st_t nxt;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic scl_q;
		logic sda_q;
		logic sda_oe;
		logic [5:0] ptr;
		logic [2:0] sub;
		logic [1:0] mode;
		logic bias;
		logic en;
		logic bank_in;
		logic bank_out;
		logic alt;
		logic [1:0] rate;
		logic bank_eff;
		logic vis;
		logic wv;
		logic [WR_W-1:0] wword;
	} lcdf_front_st_t;
	lcdf_front_st_t r_reg;
	lcdf_front_st_t r_next;
	logic rise;
	logic fall;
	logic start;
	logic stop;
	logic rx;
	logic done;
	logic addr_ok;
	logic multi;
	logic sub_hit;
	logic blinking;
	logic alt_eff;
	logic phase;
	logic [5:0] step;
	logic [5:0] sum;
	lcdf_if #(.W(WR_W)) push_if();
	lcdf_if #(.W(WR_W)) pop_if();

	// ==========================================
	// Submodules
	lcdf_fifo #(.W(WR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.wr(push_if),
		.rd(pop_if)
	);
	lcdf_blink u_blink (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_tick(i_disp_tick),
		.i_rate(r_reg.rate),
		.o_phase(phase)
	);

	// ==========================================
	// Bus events from the previous line levels
	assign rise = !r_reg.scl_q && i_scl;
	assign fall = r_reg.scl_q && !i_scl;
	assign start = r_reg.scl_q && i_scl && r_reg.sda_q && !i_sda;
	assign stop = r_reg.scl_q && i_scl && !r_reg.sda_q && i_sda;
	assign rx = (r_reg.st == ST_ADDR) || (r_reg.st == ST_CMD) || (r_reg.st == ST_DATA);
	assign done = rx && fall && (r_reg.cnt == BYTE_BITS);
	// Address check: prefix, strap level and write direction
	assign addr_ok = (r_reg.sh[7:2] == ADDR_PREFIX)
		&& (r_reg.sh[1] == i_addr_select_strap)
		&& !r_reg.sh[0];
	assign multi = (r_reg.mode == MODE_3BP) || (r_reg.mode == MODE_4BP);
	assign sub_hit = (r_reg.sub == i_hw_subaddress_straps);
	assign blinking = (r_reg.rate != 2'h0);
	assign alt_eff = r_reg.alt && !multi;
	assign sum = r_reg.ptr + step;
	// Pointer step per drive mode
	always_comb begin
		unique case (r_reg.mode)
			MODE_STATIC: step = STEP_STATIC;
			MODE_2BP: step = STEP_2BP;
			MODE_3BP: step = STEP_3BP;
			default: step = STEP_4BP;
		endcase
	end

	// ==========================================
	// Next state of the whole front end
	always_comb begin
		r_next = r_reg;
		r_next.scl_q = i_scl;
		r_next.sda_q = i_sda;
		push_if.valid = 1'b0;
		push_if.data = {r_reg.bank_in, r_reg.ptr, r_reg.sh};
		if (start) begin
			// A repeated START closes the old transfer like a STOP
			r_next.st = ST_ADDR;
			r_next.cnt = 4'h0;
			r_next.sda_oe = 1'b0;
		end else if (stop) begin
			r_next.st = ST_IDLE;
			r_next.sda_oe = 1'b0;
		end else if (r_reg.st == ST_ACK) begin
			if (fall) begin
				r_next.sda_oe = 1'b0;
				r_next.st = r_reg.nxt;
				r_next.cnt = 4'h0;
			end
		end else if (rx && rise && (r_reg.cnt < BYTE_BITS)) begin
			r_next.sh = {r_reg.sh[6:0], i_sda};
			r_next.cnt = r_reg.cnt + 4'h1;
		end else if (done) begin
			r_next.st = ST_ACK;
			unique case (r_reg.st)
				ST_ADDR: begin
					r_next.sda_oe = addr_ok;
					r_next.nxt = addr_ok ? ST_CMD : ST_IGN;
				end
				ST_CMD: begin
					r_next.sda_oe = 1'b1;
					r_next.nxt = r_reg.sh[7] ? ST_CMD : ST_DATA;
					if (!r_reg.sh[6]) begin
						r_next.ptr = r_reg.sh[5:0];
					end else if (r_reg.sh[6:5] == OP_MODE) begin
						r_next.mode = r_reg.sh[1:0];
						r_next.bias = r_reg.sh[2];
						r_next.en = r_reg.sh[3];
					end else if (r_reg.sh[6:3] == OP_DEVSEL) begin
						r_next.sub = r_reg.sh[2:0];
					end else if (r_reg.sh[6:2] == OP_BANK) begin
						if (!multi) begin
							r_next.bank_in = r_reg.sh[1];
							r_next.bank_out = r_reg.sh[0];
						end
					end else if (r_reg.sh[6:3] == OP_BLINK) begin
						r_next.alt = r_reg.sh[2];
						r_next.rate = r_reg.sh[1:0];
					end
				end
				ST_DATA: begin
					// A full FIFO drops the byte and answers with no acknowledge
					push_if.valid = sub_hit;
					r_next.sda_oe = sub_hit && push_if.ready;
					r_next.nxt = ST_DATA;
					// Pointer moves even when the write is skipped
					if (sum > PTR_LAST) begin
						r_next.ptr = sum - RAM_WORDS;
						r_next.sub = r_reg.sub + 3'h1;
					end else begin
						r_next.ptr = sum;
					end
				end
				default: begin
					r_next.st = ST_IDLE;
				end
			endcase
		end
		// Display view: alternate bank swap or on/off blink
		r_next.bank_eff = !multi && (r_reg.bank_out ^ (alt_eff && blinking && phase));
		r_next.vis = r_reg.en && !(blinking && !alt_eff && phase);
		// Output stage refills whenever it is empty or being taken
		pop_if.ready = !r_reg.wv || i_wr_ready;
		if (pop_if.valid && pop_if.ready) begin
			r_next.wv = 1'b1;
			r_next.wword = pop_if.data;
		end else if (i_wr_ready) begin
			r_next.wv = 1'b0;
		end
	end

	// State register
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			r_reg <= '0;
			r_reg.st <= ST_IDLE;
			r_reg.nxt <= ST_IDLE;
			r_reg.scl_q <= 1'b1;
			r_reg.sda_q <= 1'b1;
			r_reg.mode <= RST_MODE;
			r_reg.ptr <= RST_PTR;
			r_reg.sub <= RST_SUB;
		end else begin
			r_reg <= r_next;
		end
	end

	// ==========================================
	// Outputs from the state register, except the SDA output level, which is tied low
	assign o_sda_o = 1'b0;
	assign o_sda_oe = r_reg.sda_oe;
	assign o_drive_mode = r_reg.mode;
	assign o_bias_half = r_reg.bias;
	assign o_disp_visible = r_reg.vis;
	assign o_bank_in = r_reg.bank_in;
	assign o_bank_out = r_reg.bank_eff;
	assign o_blink_rate_field = r_reg.rate;
	assign o_blink_alt = r_reg.alt;
	assign o_data_ptr = r_reg.ptr;
	assign o_sub_cnt = r_reg.sub;
	assign o_wr_valid = r_reg.wv;
	assign o_wr_bank = r_reg.wword[14];
	assign o_wr_addr = r_reg.wword[13:8];
	assign o_wr_data = r_reg.wword[7:0];

	// ==========================================
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	chk_ack_only_slot: assert property (
		r_reg.sda_oe |-> (r_reg.st == ST_ACK)) else $error("SDA driven outside acknowledge");
	chk_addr_answer: assert property (
		(done && r_reg.st == ST_ADDR) |=> (r_reg.sda_oe == $past(addr_ok))) else $error("address answer wrong");
	chk_ign_holds: assert property (
		(r_reg.st == ST_IGN && !start && !stop) |=> (r_reg.st == ST_IGN && !r_reg.sda_oe))
		else $error("ignored transfer left early");
	chk_cmd_ack: assert property (
		(done && r_reg.st == ST_CMD) |=> r_reg.sda_oe ##1 (r_reg.st == ST_ACK)) else $error("command not acknowledged");
	chk_cont_flag: assert property (
		(done && r_reg.st == ST_CMD) |=> (r_reg.nxt == ($past(r_reg.sh[7]) ? ST_CMD : ST_DATA)))
		else $error("continuation flag misread");
	chk_data_ack: assert property (
		(done && r_reg.st == ST_DATA) |=> (r_reg.sda_oe == $past(sub_hit && push_if.ready)))
		else $error("data acknowledge wrong");
	chk_ptr_step: assert property (
		(done && r_reg.st == ST_DATA && sum <= PTR_LAST) |=> (r_reg.ptr == $past(sum)))
		else $error("pointer step wrong");
	chk_ptr_wrap: assert property (
		(done && r_reg.st == ST_DATA && sum > PTR_LAST) |=> (r_reg.sub == $past(r_reg.sub) + 3'h1))
		else $error("subaddress not bumped on overflow");
	chk_bank_locked: assert property (
		(multi && !start) |=> $stable(r_reg.bank_in) && $stable(r_reg.bank_out)) else $error("bank moved in multiplex");
	chk_push_match: assert property (
		push_if.valid |-> (sub_hit && r_reg.st == ST_DATA)) else $error("write for other subaddress");
	chk_no_alt_multi: assert property (
		multi |=> !r_reg.bank_eff) else $error("bank swap in multiplex mode");
	// Address byte refusals: wrong strap level, read direction
	chk_strap_level: assert property (
		(done && r_reg.st == ST_ADDR && r_reg.sh[1] != i_addr_select_strap) |=> !r_reg.sda_oe)
		else $error("address with other strap level answered");
	chk_read_refused: assert property (
		(done && r_reg.st == ST_ADDR && r_reg.sh[0]) |=> (!r_reg.sda_oe && r_reg.nxt == ST_IGN))
		else $error("read access answered");
	// Framing: STOP idles, START restarts, acknowledge ends with its pulse
	chk_stop_idles: assert property (
		stop |=> (r_reg.st == ST_IDLE && !r_reg.sda_oe))
		else $error("STOP did not end the transfer");
	chk_start_restarts: assert property (
		start |=> (r_reg.st == ST_ADDR && r_reg.cnt == 4'h0 && !r_reg.sda_oe))
		else $error("START did not restart the transfer");
	chk_ack_release: assert property (
		(r_reg.st == ST_ACK && fall) |=> !r_reg.sda_oe)
		else $error("acknowledge held past its clock pulse");
	// Command decode: every field lands at the acknowledge edge, never earlier
	chk_mode_load: assert property (
		(done && r_reg.st == ST_CMD && r_reg.sh[6:5] == OP_MODE)
		|=> (r_reg.mode == $past(r_reg.sh[1:0]) && r_reg.bias == $past(r_reg.sh[2])))
		else $error("mode-set fields not loaded");
	chk_disp_enable: assert property (
		(done && r_reg.st == ST_CMD && r_reg.sh[6:5] == OP_MODE)
		|=> (r_reg.en == $past(r_reg.sh[3])))
		else $error("display enable not loaded");
	chk_ptr_load: assert property (
		(done && r_reg.st == ST_CMD && !r_reg.sh[6]) |=> (r_reg.ptr == $past(r_reg.sh[5:0])))
		else $error("data pointer not loaded");
	chk_sub_load: assert property (
		(done && r_reg.st == ST_CMD && r_reg.sh[6:3] == OP_DEVSEL)
		|=> (r_reg.sub == $past(r_reg.sh[2:0])))
		else $error("subaddress counter not loaded");
	chk_bank_load: assert property (
		(done && r_reg.st == ST_CMD && r_reg.sh[6:2] == OP_BANK && !multi)
		|=> (r_reg.bank_in == $past(r_reg.sh[1]) && r_reg.bank_out == $past(r_reg.sh[0])))
		else $error("bank selection not loaded");
	chk_blink_load: assert property (
		(done && r_reg.st == ST_CMD && r_reg.sh[6:3] == OP_BLINK)
		|=> (r_reg.rate == $past(r_reg.sh[1:0]) && r_reg.alt == $past(r_reg.sh[2])))
		else $error("blink selection not loaded");
	chk_cmd_timing: assert property (
		!(done && r_reg.st == ST_CMD)
		|=> ($stable(r_reg.mode) && $stable(r_reg.en) && $stable(r_reg.rate)))
		else $error("command applied before its byte completed");
	// Data phase: skipped writes still move the pointer, output word stands
	chk_skip_moves: assert property (
		(done && r_reg.st == ST_DATA && !sub_hit && sum <= PTR_LAST)
		|=> (r_reg.ptr == $past(sum)))
		else $error("pointer stopped on skipped write");
	chk_word_stands: assert property (
		(r_reg.wv && !i_wr_ready) |=> (r_reg.wv && $stable(r_reg.wword)))
		else $error("write word changed before it was taken");
	cov_addr_acked: cover property (done && r_reg.st == ST_ADDR && addr_ok);
	cov_data_pushed: cover property (push_if.valid && push_if.ready);
	cov_ptr_overflow: cover property (done && r_reg.st == ST_DATA && sum > PTR_LAST);
	cov_read_refused: cover property (done && r_reg.st == ST_ADDR && r_reg.sh[0]);
	cov_alt_swap: cover property (!multi && r_reg.alt && blinking && phase);
endmodule // lcdf_front
`default_nettype wire

// File: verif/lcdf_master.sv
// Two-wire bus master model: START, STOP and byte writes with acknowledge.
// Assumes the bench resolves the pulled-up SDA wire and feeds it to i_sda.
`timescale 1ns/10ps
`default_nettype none
module lcdf_master (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	// ==========================================
	// Idle bus; levels change only after falling clock edges
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	// Four clocks a level, double the front end's minimum
	task automatic hold();
		repeat (4) @(negedge i_clk);
	endtask
	// START, and a repeated START when SCL is low
	task automatic start();
		o_sda = 1'b1;
		hold();
		o_scl = 1'b1;
		hold();
		o_sda = 1'b0;
		hold();
		o_scl = 1'b0;
		hold();
	endtask
	// STOP closes the transfer
	task automatic stop();
		o_sda = 1'b0;
		hold();
		o_scl = 1'b1;
		hold();
		o_sda = 1'b1;
		hold();
	endtask
	// Byte MSB first; SDA released for the ninth pulse
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			o_sda = b[i];
			hold();
			o_scl = 1'b1;
			hold();
			o_scl = 1'b0;
		end
		o_sda = 1'b1;
		hold();
		o_scl = 1'b1;
		repeat (2) @(negedge i_clk);
		ack = !i_sda;
		repeat (2) @(negedge i_clk);
		o_scl = 1'b0;
	endtask
endmodule // lcdf_master
`default_nettype wire

// File: verif/test_lcdf_front.sv
// Self-checking bench for the display driver bus front end.
// Assumes lcdf_master drives the bus; SDA is a pulled-up wired-AND.
`timescale 1ns/10ps
`default_nettype none
module test_lcdf_front import lcdf_pkg::*;;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic strap = 1'b0;
	logic [2:0] subs = 3'h0;
	logic tick = 1'b1;
	logic wr_ready = 1'b1;
	logic scl, m_sda, sda_o, sda_oe, bias, vis, bank_in, bank_out, alt, wr_valid, wr_bank;
	logic [1:0] mode, rate;
	logic [5:0] ptr, wr_addr;
	logic [2:0] sub;
	logic [7:0] wr_data;
	wire logic sda;
	int errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [14:0] words[$];
	localparam logic [1:0] MODES [4] = '{MODE_STATIC, MODE_2BP, MODE_3BP, MODE_4BP};
	localparam logic [5:0] STEPS [4] = '{STEP_STATIC, STEP_2BP, STEP_3BP, STEP_4BP};
	// ==========================================
	// Clock, wired SDA, write stream capture
	always #5 i_clk = ~i_clk;
	assign sda = m_sda & ~(sda_oe & ~sda_o);
	always @(posedge i_clk) begin
		if (wr_valid && wr_ready) begin
			words.push_back({wr_bank, wr_addr, wr_data});
		end
	end
	lcdf_master u_m (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));
	lcdf_front u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o),
		.o_sda_oe(sda_oe), .i_addr_select_strap(strap), .i_hw_subaddress_straps(subs),
		.i_disp_tick(tick), .o_drive_mode(mode), .o_bias_half(bias), .o_disp_visible(vis),
		.o_bank_in(bank_in), .o_bank_out(bank_out), .o_blink_rate_field(rate), .o_blink_alt(alt),
		.o_data_ptr(ptr), .o_sub_cnt(sub), .o_wr_valid(wr_valid), .i_wr_ready(wr_ready),
		.o_wr_addr(wr_addr), .o_wr_bank(wr_bank), .o_wr_data(wr_data));
	// ==========================================
	// Shared helpers
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tx(input logic [7:0] b, input logic exp);
		logic a;
		u_m.send(b, a);
		check(16'(a), 16'(exp));
	endtask
	task automatic do_reset();
		i_rst = 1'b1;
		repeat (20) @(negedge i_clk);
		i_rst = 1'b0;
		repeat (2) @(negedge i_clk);
	endtask
	task automatic final_report();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset();
		check(16'({mode, ptr, sub, vis, wr_valid, sda_oe}), 16'({RST_MODE, RST_PTR, RST_SUB, 3'h0}));
	endtask
	// Wrong prefix, wrong strap bit, read bit; ignored byte after a refusal
	task automatic t_addr();
		u_m.start();
		tx(8'h78, 1'b0);
		u_m.start();
		tx(8'h72, 1'b0);
		tx(8'h60, 1'b0);
		u_m.start();
		tx(8'h71, 1'b0);
		u_m.stop();
		strap = 1'b1;
		u_m.start();
		tx(8'h72, 1'b1);
		u_m.stop();
		strap = 1'b0;
	endtask
	// Every drive mode: decode, pointer load, one stored byte, step
	task automatic t_modes();
		for (int i = 0; i < 4; i++) begin
			u_m.start();
			tx(8'h70, 1'b1);
			tx({3'b110, 1'b0, i[0], i[1], MODES[i]}, 1'b1);
			tx(8'h80, 1'b1);
			tx(8'h60, 1'b1);
			check(16'({mode, bias, vis, sub}), 16'({MODES[i], i[1], i[0], 3'h0}));
			tx(8'ha0 + 8'(i), 1'b1);
			u_m.stop();
			check(16'(ptr), 16'(STEPS[i]));
			check(16'(words.pop_front()), 16'({7'h00, 8'ha0 + 8'(i)}));
		end
	endtask
	// Bank select in two and three backplanes, then each blink rate
	task automatic t_bank();
		u_m.start();
		tx(8'h70, 1'b1);
		tx(8'hca, 1'b1);
		tx(8'h7b, 1'b1);
		check(16'({bank_in, bank_out}), 16'h3);
		u_m.start();
		tx(8'h70, 1'b1);
		tx(8'hcb, 1'b1);
		tx(8'hf8, 1'b1);
		check(16'({bank_in, bank_out}), 16'h2);
		for (int r = 3; r >= 0; r--) begin
			tx({5'b11110, 1'b1, 2'(r)}, 1'b1);
			check(16'({rate, alt, bank_out}), 16'({2'(r), 2'b10}));
		end
		u_m.stop();
	endtask
	// Cycles between two changes of the visible flag (sel 0) or the shown bank (sel 1)
	task automatic gap(input logic sel, output int n);
		logic v;
		n = 0;
		@(negedge i_clk);
		v = sel ? bank_out : vis;
		while ((sel ? bank_out : vis) == v && n < 4000) begin
			@(negedge i_clk);
			n++;
		end
		n = 0;
		v = sel ? bank_out : vis;
		while ((sel ? bank_out : vis) == v && n < 4000) begin
			@(negedge i_clk);
			n++;
		end
	endtask
	// Rate 1 blinking in static mode; tick tied high, so half periods are in clocks
	task automatic t_blink();
		int n;
		u_m.start();
		tx(8'h70, 1'b1);
		tx(8'hc9, 1'b1);
		tx(8'h71, 1'b1);
		u_m.stop();
		gap(1'b0, n);
		check(16'(n), 16'(BLINK_DIV1 / 2));
		u_m.start();
		tx(8'h70, 1'b1);
		tx(8'h75, 1'b1);
		u_m.stop();
		gap(1'b1, n);
		check(16'(n), 16'(BLINK_DIV1 / 2));
		check(16'(vis), 16'h1);
	endtask
	// Subaddress match, pointer overflow, suppressed write, repeated START
	task automatic t_sub();
		do_reset();
		subs = 3'h5;
		u_m.start();
		tx(8'h70, 1'b1);
		tx(8'hcd, 1'b1);
		tx(8'ha6, 1'b1);
		tx(8'h65, 1'b1);
		tx(8'h3c, 1'b1);
		check(16'({sub, ptr}), 16'({3'h6, 6'h06}));
		tx(8'h3d, 1'b0);
		check(16'({sub, ptr}), 16'({3'h6, 6'h0e}));
		u_m.start();
		tx(8'h70, 1'b1);
		u_m.stop();
		check(16'(words.pop_front()), 16'({1'b0, 6'h26, 8'h3c}));
		check(16'(words.size()), 16'h0);
		subs = 3'h0;
	endtask
	// Stalled consumer: buffer fills until a byte is refused, then drains
	task automatic t_fifo();
		do_reset();
		wr_ready = 1'b0;
		u_m.start();
		tx(8'h70, 1'b1);
		tx(8'h00, 1'b1);
		for (int k = 0; k < 17; k++) begin
			tx(8'(k), 1'b1);
		end
		tx(8'h55, 1'b0);
		u_m.stop();
		wr_ready = 1'b1;
		repeat (30) @(negedge i_clk);
		check(16'(words.size()), 16'd17);
		for (int k = 0; k < 17; k++) begin
			check(16'(words.pop_front()), 16'({1'b0, 6'(2 * k), 8'(k)}));
		end
	endtask
	// ==========================================
	// Cycle ceiling, then the main sequence
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			final_report();
		end
	end
	initial begin
		do_reset();
		t_reset();
		t_addr();
		t_modes();
		t_bank();
		t_blink();
		t_sub();
		t_fifo();
		final_report();
	end
endmodule // test_lcdf_front
`default_nettype wire
